//--- rio_remote_io.sv
// Remote I/O controller: remote inputs, status outputs, meter scaling, register slave
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "rio_regs.svh"

module rio_remote_io
	import rio_pkg::*;
#(
	parameter int unsigned N_IN        = 24,
	parameter int unsigned N_OUT       = 24,
	parameter int unsigned N_AN        = 8,
	parameter int unsigned REPEAT_CYC  = `RIO_REPEAT_NS / `RIO_CLK_PERIOD_NS
)
(
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	input  wire rio_avs_req_t           i_avs,
	output logic [31:0]                 o_avs_readdata,
	output logic                        o_avs_waitrequest,
	input  wire logic [N_IN-1:0]        i_remote_in,
	input  wire logic                   i_remote_mode,
	input  wire logic                   i_rf_is_on,
	input  wire logic [27:0]            i_alarm,
	input  wire logic [N_AN-1:0][15:0]  i_meter,
	output rio_cmd_t                    o_cmd,
	output logic                        o_exciter_b,
	output logic                        o_autochg_en,
	output logic [N_OUT-1:0]            o_remote_out,
	output logic [N_AN-1:0][12:0]       o_meter_mv
);

	////////////////////////////////////////////////////////////////////////////////
	// Configuration storage

	logic [11:0]        in_cfg_q  [N_IN];
	logic [8:0]         out_cfg_q [N_OUT];
	logic [15:0]        an_fsv_q  [N_AN];
	logic [12:0]        an_mv_q   [N_AN];
	logic               ack_q;
	logic [31:0]        rdata_q;
	logic               req_w;
	logic [7:0]         widx_w;

	assign req_w  = i_avs.read | i_avs.write;
	assign widx_w = i_avs.address[9:2];

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers and edge detection

	logic [N_IN-1:0]    sync1_q;
	logic [N_IN-1:0]    sync2_q;
	logic [N_IN-1:0]    prev_q;
	logic [N_IN-1:0]    rise_w;
	logic [N_IN-1:0]    fall_w;

	// Two flops per input, third flop holds the previous sample
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q  <= '0;
		end
		else
		begin
			sync1_q <= i_remote_in; // R23
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	assign rise_w = sync2_q & ~prev_q; // R23
	assign fall_w = ~sync2_q & prev_q; // R23

	////////////////////////////////////////////////////////////////////////////////
	// Per-input mode decode

	logic [N_IN-1:0]    act_w;
	logic [N_IN-1:0]    deact_w;
	logic [N_IN-1:0]    hold_w;
	logic [N_IN-1:0]    step_w;
	logic [N_IN-1:0]    lvl_start_w;
	logic [N_IN-1:0]    tog_q;
	logic [N_IN-1:0]    hold_prev_q;
	logic [26:0]        rep_cnt_q [N_IN];

	for (genvar gi = 0; gi < N_IN; gi++)
	begin : g_in
		rio_func_t  fn;
		rio_mode_t  md;
		logic       en;
		logic       a;
		logic       d;
		logic       h;

		assign fn = rio_func_t'(in_cfg_q[gi][`RIO_IN_FUNC_LSB +: 4]);
		assign md = rio_mode_t'(in_cfg_q[gi][`RIO_IN_MODE_LSB +: 4]);
		assign en = i_remote_mode && (fn != RIO_FN_NONE); // R02 R03

		// Edge and level interpretation of the configured mode
		always_comb
		begin
			a = 1'b0;
			d = 1'b0;
			h = 1'b0;
			unique case (md)
				RIO_MD_FALL_ON:          a = fall_w[gi];                   // R11
				RIO_MD_RISE_ON:          a = rise_w[gi];                   // R11
				RIO_MD_FALL_OFF:         d = fall_w[gi];                   // R12
				RIO_MD_RISE_OFF:         d = rise_w[gi];                   // R12
				RIO_MD_FALL_TOG:
				begin
					a = fall_w[gi] & tog_q[gi];                            // R13
					d = fall_w[gi] & ~tog_q[gi];
				end
				RIO_MD_RISE_TOG:
				begin
					a = rise_w[gi] & ~tog_q[gi];                           // R13
					d = rise_w[gi] & tog_q[gi];
				end
				RIO_MD_RISE_ON_FALL_OFF:
				begin
					a = rise_w[gi];                                        // R14
					d = fall_w[gi];
				end
				RIO_MD_FALL_ON_RISE_OFF:
				begin
					a = fall_w[gi];                                        // R14
					d = rise_w[gi];
				end
				RIO_MD_LVL_HIGH:         h = sync2_q[gi];                  // R15 R16
				RIO_MD_LVL_LOW:          h = ~sync2_q[gi];                 // R15 R16
				default:                 a = 1'b0;
			endcase
		end

		assign act_w[gi]       = en & a;
		assign deact_w[gi]     = en & d;
		assign hold_w[gi]      = en & h;
		assign lvl_start_w[gi] = hold_w[gi] & ~hold_prev_q[gi];
		// Step on entering the level, then once per repeat period
		assign step_w[gi] = lvl_start_w[gi] |
			(hold_w[gi] && rep_cnt_q[gi] == 27'(REPEAT_CYC - 1)); // R06 R15

		// Toggle phase and hold-repeat counter
		always_ff @(posedge i_clk or negedge i_rst_n)
		begin
			if (!i_rst_n)
			begin
				tog_q[gi]       <= 1'b0;
				hold_prev_q[gi] <= 1'b0;
				rep_cnt_q[gi]   <= '0;
			end
			else
			begin
				if (act_w[gi] | deact_w[gi])
					tog_q[gi] <= ~tog_q[gi]; // R13
				hold_prev_q[gi] <= hold_w[gi];
				if (!hold_w[gi] || step_w[gi])
					rep_cnt_q[gi] <= '0;
				else
					rep_cnt_q[gi] <= rep_cnt_q[gi] + 27'd1; // R06
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command merge across inputs

	rio_cmd_t           cmd_d;
	logic               exc_set_b_w;
	logic               exc_set_a_w;
	logic               autochg_flip_w;

	// Lowest-numbered input wins the preset index when several fire at once
	always_comb
	begin
		rio_func_t f;
		f              = RIO_FN_NONE;
		cmd_d          = '0;
		exc_set_b_w    = 1'b0;
		exc_set_a_w    = 1'b0;
		autochg_flip_w = 1'b0;
		for (int i = N_IN - 1; i >= 0; i--) // R01
		begin
			f = rio_func_t'(in_cfg_q[i][`RIO_IN_FUNC_LSB +: 4]);
			unique case (f)
				RIO_FN_RF:
				begin
					cmd_d.rf_on  = cmd_d.rf_on | act_w[i];    // R04
					cmd_d.rf_off = cmd_d.rf_off | deact_w[i]; // R04
				end
				RIO_FN_RESET:   cmd_d.sys_reset = cmd_d.sys_reset | act_w[i]; // R05
				RIO_FN_PWR_INC: cmd_d.pwr_inc = cmd_d.pwr_inc | act_w[i] | step_w[i]; // R06
				RIO_FN_PWR_DEC: cmd_d.pwr_dec = cmd_d.pwr_dec | act_w[i] | step_w[i]; // R06
				RIO_FN_EXCITER:
				begin
					exc_set_b_w = exc_set_b_w | act_w[i];   // R07
					exc_set_a_w = exc_set_a_w | deact_w[i]; // R07
				end
				RIO_FN_AUTOCHG: autochg_flip_w = autochg_flip_w ^ act_w[i]; // R08
				RIO_FN_WDOG:    cmd_d.wdog = cmd_d.wdog | act_w[i]; // R09
				RIO_FN_PRESET:
				begin
					if (act_w[i] | lvl_start_w[i]) // R10 R16
					begin
						cmd_d.preset_sel = 1'b1;
						cmd_d.preset_idx = in_cfg_q[i][`RIO_IN_PRESET_LSB +: 4];
					end
				end
				default:        cmd_d.wdog = cmd_d.wdog; // R03
			endcase
		end
	end

	// Command pulses, exciter choice and changeover state
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_cmd        <= '0;
			o_exciter_b  <= 1'b0;
			o_autochg_en <= 1'b0;
		end
		else
		begin
			o_cmd <= cmd_d;
			if (exc_set_b_w)
				o_exciter_b <= 1'b1; // R07
			else if (exc_set_a_w)
				o_exciter_b <= 1'b0;
			if (autochg_flip_w)
				o_autochg_en <= ~o_autochg_en; // R08
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Digital status outputs

	logic [31:0]        chan_w;

	// Channel 0 RF on, 1 exciter B, 2 auto changeover, 3 remote, 4.. alarms
	assign chan_w = {i_alarm, i_remote_mode, o_autochg_en, o_exciter_b, i_rf_is_on};

	// Polarity 0 drives low when true, 1 drives high when true
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_remote_out <= '1;
		else
			for (int o = 0; o < N_OUT; o++) // R18
				o_remote_out[o] <= out_cfg_q[o][`RIO_OUT_POL_BIT] ~^
					chan_w[out_cfg_q[o][`RIO_OUT_CHAN_LSB +: 5]]; // R19 R20
	end

	////////////////////////////////////////////////////////////////////////////////
	// Analog meter scaling, one meter per cycle

	logic [2:0]         an_idx_q;
	logic [28:0]        an_prod_w;
	logic [28:0]        an_quot_w;
	logic [12:0]        an_mv_w;

	assign an_prod_w = 29'(i_meter[an_idx_q]) * 29'(an_mv_q[an_idx_q]); // R22
	assign an_quot_w = (an_fsv_q[an_idx_q] == 16'h0000) ? 29'h0 :
		an_prod_w / 29'(an_fsv_q[an_idx_q]);
	// Readings above full scale clip at the full-scale voltage
	assign an_mv_w = (an_quot_w > 29'(an_mv_q[an_idx_q])) ?
		an_mv_q[an_idx_q] : an_quot_w[12:0];

	// Round-robin refresh of the meter outputs
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			an_idx_q   <= '0;
			o_meter_mv <= '0;
		end
		else
		begin
			an_idx_q             <= (32'(an_idx_q) == N_AN - 1) ? 3'h0 : an_idx_q + 3'h1;
			o_meter_mv[an_idx_q] <= an_mv_w; // R21 R22
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait cycle, answer on the second

	assign o_avs_waitrequest = req_w & ~ack_q;
	assign o_avs_readdata    = rdata_q;

	// Acknowledge flag
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			ack_q <= 1'b0;
		else
			ack_q <= req_w & ~ack_q;
	end

	// Register writes, taken at the accepting edge
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			for (int i = 0; i < N_IN; i++)
				in_cfg_q[i] <= `RIO_IN_CFG_RST;
			for (int o = 0; o < N_OUT; o++)
				out_cfg_q[o] <= `RIO_OUT_CFG_RST;
			for (int m = 0; m < N_AN; m++)
			begin
				an_fsv_q[m] <= `RIO_AN_FSV_RST;
				an_mv_q[m]  <= `RIO_AN_MV_RST; // R21
			end
		end
		else if (i_avs.write && ack_q)
		begin
			for (int i = 0; i < N_IN; i++)
				if (i_avs.address == `RIO_IN_CFG_BASE + 10'(4 * i))
					in_cfg_q[i] <= i_avs.writedata[11:0]; // R01
			for (int o = 0; o < N_OUT; o++)
				if (i_avs.address == `RIO_OUT_CFG_BASE + 10'(4 * o))
					out_cfg_q[o] <= i_avs.writedata[8:0]; // R18
			for (int m = 0; m < N_AN; m++)
			begin
				if (i_avs.address == `RIO_AN_FSV_BASE + 10'(4 * m))
					an_fsv_q[m] <= i_avs.writedata[15:0];
				if (i_avs.address == `RIO_AN_MV_BASE + 10'(4 * m))
				begin
					// Full-scale voltage is held within 1 V to 6 V
					if (i_avs.writedata[31:0] < 32'(`RIO_AN_MV_MIN))
						an_mv_q[m] <= `RIO_AN_MV_MIN; // R21
					else if (i_avs.writedata[31:0] > 32'(`RIO_AN_MV_MAX))
						an_mv_q[m] <= `RIO_AN_MV_MAX; // R21
					else
						an_mv_q[m] <= i_avs.writedata[12:0];
				end
			end
		end
	end

	// Read mux, latched in the wait cycle; unmapped words read zero
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rdata_q <= '0;
		else if (i_avs.read && !ack_q)
		begin
			rdata_q <= '0;
			for (int i = 0; i < N_IN; i++)
				if (i_avs.address == `RIO_IN_CFG_BASE + 10'(4 * i))
					rdata_q <= {20'h0, in_cfg_q[i]};
			for (int o = 0; o < N_OUT; o++)
				if (i_avs.address == `RIO_OUT_CFG_BASE + 10'(4 * o))
					rdata_q <= {23'h0, out_cfg_q[o]};
			for (int m = 0; m < N_AN; m++)
			begin
				if (i_avs.address == `RIO_AN_FSV_BASE + 10'(4 * m))
					rdata_q <= {16'h0, an_fsv_q[m]};
				if (i_avs.address == `RIO_AN_MV_BASE + 10'(4 * m))
					rdata_q <= {19'h0, an_mv_q[m]};
			end
			if (i_avs.address == `RIO_IN_LEVEL)
				rdata_q <= 32'(sync2_q); // R17
			if (i_avs.address == `RIO_OUT_LEVEL)
				rdata_q <= 32'(o_remote_out); // R17
			if (i_avs.address == `RIO_STATE)
				rdata_q <= {28'h0, i_remote_mode, o_autochg_en, o_exciter_b, i_rf_is_on};
		end
	end

	logic unused_w;
	assign unused_w = ^{widx_w};

endmodule : rio_remote_io
`default_nettype wire

//--- rio_regs.svh
// Register offsets, field positions, reset values and timing counts of the remote I/O block
// How it works
// R01 - 24 inputs, each with function and mode
// R02 - Inputs act only while status is remote
// R03 - Unassigned inputs never affect the transmitter
// R04 - RF input requests RF on or off
// R05 - Reset input pulses the system reset
// R06 - Power input steps 100W, repeats every half-second
// R07 - Exciter input selects exciter A or B
// R08 - Changeover input inverts auto changeover per activation
// R09 - Watchdog input pulses the interface processor reset
// R10 - Preset input makes its preset active
// R11 - Turn-on modes: chosen edge activates
// R12 - Turn-off modes: chosen edge deactivates
// R13 - Toggle modes alternate activate and deactivate
// R14 - Combined modes: one edge on, other off
// R15 - Power level modes step while level holds
// R16 - Preset level modes select preset on level
// R17 - Input and output levels are readable
// R18 - 24 outputs, each assigned one status channel
// R19 - Each output has selectable polarity
// R20 - Exciter output shows A or B by polarity
// R21 - Eight meters, full scale 1 to 6 V
// R22 - Voltage is value over full scale times volts
// R23 - Inputs synchronised, edges from sampled values
// R24 - Far side holds levels several clocks
`ifndef RIO_REGS_SVH
`define RIO_REGS_SVH
`define RIO_IN_CFG_BASE    10'h000
`define RIO_OUT_CFG_BASE   10'h080
`define RIO_AN_FSV_BASE    10'h100
`define RIO_AN_MV_BASE     10'h120
`define RIO_IN_LEVEL       10'h140
`define RIO_OUT_LEVEL      10'h144
`define RIO_STATE          10'h148
`define RIO_IN_FUNC_LSB    0
`define RIO_IN_MODE_LSB    4
`define RIO_IN_PRESET_LSB  8
`define RIO_OUT_CHAN_LSB   0
`define RIO_OUT_POL_BIT    8
`define RIO_IN_CFG_RST     12'h000
`define RIO_OUT_CFG_RST    9'h000
`define RIO_AN_FSV_RST     16'hFFFF
`define RIO_AN_MV_RST      13'h1770
`define RIO_AN_MV_MIN      13'h03E8
`define RIO_AN_MV_MAX      13'h1770
`define RIO_CLK_PERIOD_NS  5
`define RIO_REPEAT_NS      500000000
`endif

//--- rio_pkg.sv
// Types shared by the remote I/O block
package rio_pkg;
	// Function assigned to one remote input
	typedef enum logic [3:0] {
		RIO_FN_NONE,
		RIO_FN_RF,
		RIO_FN_RESET,
		RIO_FN_PWR_INC,
		RIO_FN_PWR_DEC,
		RIO_FN_EXCITER,
		RIO_FN_AUTOCHG,
		RIO_FN_WDOG,
		RIO_FN_PRESET
	} rio_func_t;

	// Activation behaviour of one remote input
	typedef enum logic [3:0] {
		RIO_MD_FALL_ON,
		RIO_MD_RISE_ON,
		RIO_MD_FALL_OFF,
		RIO_MD_RISE_OFF,
		RIO_MD_FALL_TOG,
		RIO_MD_RISE_TOG,
		RIO_MD_RISE_ON_FALL_OFF,
		RIO_MD_FALL_ON_RISE_OFF,
		RIO_MD_LVL_HIGH,
		RIO_MD_LVL_LOW
	} rio_mode_t;

	// Command pulses toward the transmitter control logic
	typedef struct packed {
		logic       rf_on;
		logic       rf_off;
		logic       sys_reset;
		logic       pwr_inc;
		logic       pwr_dec;
		logic       wdog;
		logic       preset_sel;
		logic [3:0] preset_idx;
	} rio_cmd_t;

	// Avalon-MM slave request
	typedef struct packed {
		logic [9:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} rio_avs_req_t;
endpackage : rio_pkg

//--- rio_remote_io_properties.sv
// Port checks of the remote I/O controller
`timescale 1ns/100ps
`default_nettype none
module rio_remote_io_chk
	import rio_pkg::*;
#(
	parameter int unsigned N_IN = 24,
	parameter int unsigned N_AN = 8,
	parameter int unsigned REPEAT_CYC = 20
)
(
	input wire logic	i_clk,
	input wire logic	i_rst_n,
	input wire rio_avs_req_t	i_avs,
	input wire logic	o_avs_waitrequest,
	input wire logic	i_remote_mode,
	input wire rio_cmd_t	o_cmd,
	input wire logic	o_exciter_b,
	input wire logic [N_AN-1:0][12:0]	o_meter_mv
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// Bus request in progress
	wire logic req = i_avs.read | i_avs.write;
	sequence s_req_start;
		$rose(req);
	endsequence
	sequence s_local_run;
		(!i_remote_mode)[*6];
	endsequence
	////////////////////////////////////////////////////////////////////////////
	wait_first_a: assert property (s_req_start |-> o_avs_waitrequest)
		else $error("no wait cycle");
	wait_one_a: assert property (s_req_start ##1 req |-> !o_avs_waitrequest)
		else $error("wait too long");
	idle_nowait_a: assert property (!req |-> !o_avs_waitrequest)
		else $error("wait while idle");
	local_quiet_a: assert property (s_local_run |-> o_cmd == '0)
		else $error("command in local");
	rf_remote_a: assert property (o_cmd.rf_on |-> $past(i_remote_mode))
		else $error("rf on not remote");
	exc_remote_a: assert property ($changed(o_exciter_b) |-> $past(i_remote_mode))
		else $error("exciter not remote");
	idx_zero_a: assert property (!o_cmd.preset_sel |-> o_cmd.preset_idx == 4'h0)
		else $error("stray preset index");
	pwr_gap_a: assert property (o_cmd.pwr_inc |=> (!o_cmd.pwr_inc)[*8])
		else $error("power steps too close");
	meter_max_a: assert property (o_meter_mv[0] <= 13'h1770)
		else $error("meter above full scale");
endmodule : rio_remote_io_chk

bind rio_remote_io rio_remote_io_chk #(.N_IN(N_IN), .N_AN(N_AN), .REPEAT_CYC(REPEAT_CYC))
	i_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs(i_avs),
	.o_avs_waitrequest(o_avs_waitrequest), .i_remote_mode(i_remote_mode),
	.o_cmd(o_cmd), .o_exciter_b(o_exciter_b), .o_meter_mv(o_meter_mv));
`default_nettype wire

//--- rio_remote_unit.sv
// Model of the external remote control unit
`timescale 1ns/100ps
`default_nettype none
module rio_remote_unit
(
	input wire logic	i_clk,
	output logic [23:0]	o_pins
);
	// Contacts rest high
	initial o_pins = 24'hFFFFFF;
	////////////////////////////////////////////////////////////////////////////
	// Change one pin after an edge, then hold it
	task automatic set_pin(input int idx, input logic lvl);
		@(posedge i_clk);
		o_pins[idx] <= lvl;
		repeat (4) @(posedge i_clk);
	endtask : set_pin
endmodule : rio_remote_unit
`default_nettype wire

//--- remote_io_controller_tb_top.sv
// Testbench of the remote I/O controller
`timescale 1ns/100ps
`default_nettype none
module remote_io_controller_tb_top
	import rio_pkg::*;
;
	logic	i_clk = 1'b0;
	logic	i_rst_n = 1'b0;
	rio_avs_req_t	avs = '0;
	logic [31:0]	rdata;
	logic	wreq;
	wire logic [23:0]	pins;
	logic	mode = 1'b1;
	logic	rf_on = 1'b1;
	logic [27:0]	alarm = 28'h0;
	logic [7:0][15:0]	meter = 128'h8000;
	rio_cmd_t	cmd;
	logic	exc_b;
	logic	autochg;
	logic [23:0]	rout;
	logic [7:0][12:0]	mv;
	logic [3:0]	last_idx = 4'h0;
	int	cnt[7] = '{default: 0};
	int	mismatches = 0;
	int	n_checks = 0;
	always #2.5 i_clk = ~i_clk;
	rio_remote_io #(.REPEAT_CYC(20)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs(avs),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_remote_in(pins),
		.i_remote_mode(mode), .i_rf_is_on(rf_on), .i_alarm(alarm), .i_meter(meter),
		.o_cmd(cmd), .o_exciter_b(exc_b), .o_autochg_en(autochg), .o_remote_out(rout),
		.o_meter_mv(mv));
	rio_remote_unit i_ru (.i_clk(i_clk), .o_pins(pins));
	// Count command pulses, lowest index is preset select
	always @(posedge i_clk)
	begin
		for (int b = 0; b < 7; b++)
			if (cmd[4+b] === 1'b1)
				cnt[b] <= cnt[b] + 1;
		if (cmd.preset_sel === 1'b1)
			last_idx <= cmd.preset_idx;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask : cyc
	// Avalon transfer held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic rd, input logic [9:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge i_clk);
		avs.address <= a;
		avs.read <= rd;
		avs.write <= ~rd;
		avs.writedata <= d;
		n = 0;
		q = '0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (wreq !== 1'b0 && n < 50);
		if (wreq !== 1'b0)
		begin
			chk("bus_timeout", 32'h0, 32'h1);
			results();
		end
		else
		begin
			q = rdata;
			avs.read <= 1'b0;
			avs.write <= 1'b0;
		end
	endtask : bus
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b0, a, d, q);
	endtask : wr
	task automatic rd_chk(input string nm, input logic [9:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b1, a, 32'h0, q);
		chk(nm, e, q);
	endtask : rd_chk
	// Low then high on one pin, report pulse counts
	task automatic pin_cycle(input int pin, output int d[7]);
		int c0[7];
		c0 = cnt;
		i_ru.set_pin(pin, 1'b0);
		i_ru.set_pin(pin, 1'b1);
		cyc(6);
		foreach (d[b])
			d[b] = cnt[b] - c0[b];
	endtask : pin_cycle
	task automatic edge_run(input int pin, input logic [11:0] cfg, output int d[7]);
		wr(10'(pin * 4), {20'h0, cfg});
		pin_cycle(pin, d);
	endtask : edge_run
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		cyc(2);
		chk("out_after_reset", 32'h0, 32'(rout));
		rd_chk("in_cfg0", 10'h000, 32'h0);
		rd_chk("an_mv0", 10'h120, 32'h1770);
		rd_chk("unmapped", 10'h3FC, 32'h0);
		rd_chk("in_level", 10'h140, 32'hFFFFFF);
		$display("test reset done");
	endtask : t_reset
	task automatic t_outputs();
		wr(10'h094, 32'h104);
		alarm <= 28'h1;
		cyc(3);
		chk("out5_pol1_true", 32'h1, 32'(rout[5]));
		alarm <= 28'h0;
		wr(10'h094, 32'h004);
		cyc(3);
		chk("out5_pol0_false", 32'h1, 32'(rout[5]));
		rf_on <= 1'b0;
		cyc(3);
		chk("out0_rf_off", 32'h1, 32'(rout[0]));
		rf_on <= 1'b1;
		cyc(3);
		rd_chk("out_level", 10'h144, 32'h20);
		$display("test outputs done");
	endtask : t_outputs
	task automatic t_gating();
		int d[7];
		mode <= 1'b0;
		edge_run(2, 12'h001, d);
		chk("rf_on_local", 32'h0, d[6]);
		mode <= 1'b1;
		pin_cycle(2, d);
		chk("rf_on_fall", 32'h1, d[6]);
		edge_run(2, 12'h021, d);
		chk("rf_off_fall", 32'h1, d[5]);
		edge_run(3, 12'h000, d);
		chk("unassigned", 32'h0, d.sum());
		$display("test gating done");
	endtask : t_gating
	task automatic t_funcs();
		int d[7];
		logic [3:0] fn[5] = '{4'h2, 4'h7, 4'h3, 4'h4, 4'h8};
		int bt[5] = '{4, 1, 3, 2, 0};
		for (int k = 0; k < 5; k++)
		begin
			edge_run(6, {4'h9, 4'h1, fn[k]}, d);
			chk("cmd_rise_on", 32'h1, d[bt[k]]);
			chk("cmd_total", 32'h1, d.sum());
		end
		chk("preset_idx", 32'h9, 32'(last_idx));
		$display("test functions done");
	endtask : t_funcs
	task automatic t_toggle();
		int d[7];
		edge_run(7, 12'h051, d);
		chk("toggle_on", 32'h1, d[6]);
		pin_cycle(7, d);
		chk("toggle_off", 32'h1, d[5]);
		edge_run(8, 12'h016, d);
		chk("autochg_one", 32'h1, 32'(autochg));
		pin_cycle(8, d);
		chk("autochg_two", 32'h0, 32'(autochg));
		wr(10'h024, 32'h065);
		i_ru.set_pin(9, 1'b0);
		i_ru.set_pin(9, 1'b1);
		cyc(3);
		chk("exciter_b", 32'h1, 32'(exc_b));
		i_ru.set_pin(9, 1'b0);
		cyc(3);
		chk("exciter_a", 32'h0, 32'(exc_b));
		$display("test toggle done");
	endtask : t_toggle
	task automatic t_power();
		int c0;
		wr(10'h010, 32'h093);
		c0 = cnt[3];
		i_ru.set_pin(4, 1'b0);
		cyc(26);
		chk("pwr_held", 32'h2, cnt[3] - c0);
		i_ru.set_pin(4, 1'b1);
		cyc(30);
		chk("pwr_released", 32'h2, cnt[3] - c0);
		$display("test power done");
	endtask : t_power
	task automatic t_meter();
		chk("meter_half", 32'hBB8, 32'(mv[0]));
		wr(10'h120, 32'h1F4);
		rd_chk("mv_clamp", 10'h120, 32'h3E8);
		cyc(10);
		chk("meter_scaled", 32'h1F4, 32'(mv[0]));
		$display("test meter done");
	endtask : t_meter
	// Main sequence
	initial
	begin
		repeat (3) @(posedge i_clk);
		chk("out_in_reset", 32'hFFFFFF, 32'(rout));
		i_rst_n <= 1'b1;
		t_reset();
		t_outputs();
		t_gating();
		t_funcs();
		t_toggle();
		t_power();
		t_meter();
		results();
	end
endmodule : remote_io_controller_tb_top
`default_nettype wire
